// >>> src/rss_dev.sv
// Purpose: Slave end of the clock-calendar serial port with its eight-byte image.
// Assumes: NUM_REGS is a power of two; SCL and SDA are slow against clk_i.
// Notes: All pin and supply inputs pass two flip-flops; SDA is only ever pulled low.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Respond only after START plus own address.
// - Eight bytes in fixed sequential order.
// - Address auto-increments after each data byte except a refused read.
// - Low supply aborts access, clears address.
// - Ignore bus while supply stays low.
// - Master starts only on idle bus.
// - SDA change while SCL high is control.
// - START is SDA fall, SCL high.
// - STOP is SDA rise, SCL high.
// - One bit per SCL pulse, sampled high.
// - START to STOP, unlimited byte count.
// - Ninth slot carries receiver acknowledge low.
// - Addressed receiver acknowledges every byte.
// - Master acknowledges all but last read.
// - Acknowledge low stable over high phase.
// - Master leaves last read slot high.
// - Release SDA after missing acknowledge.
// - Read pointer advances only on acknowledge.
// - Byte after write address loads pointer.
module rss_dev #(
  parameter int NUM_REGS = rss_pkg::NUM_REGS,
  parameter int ADDR_W = $clog2(NUM_REGS)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial link.
  rss_if.dev bus,
  // Supply monitor: high while below backup_switchover_threshold.
  input wire logic vcc_low_i,
  // Clock-calendar side update port.
  input wire logic cal_we_i,
  input wire logic [ADDR_W-1:0] cal_idx_i,
  input wire logic [7:0] cal_data_i,
  // Image, bus write notification, selection and pointer.
  output logic [NUM_REGS-1:0][7:0] regs_o,
  output logic wr_stb_o,
  output logic [ADDR_W-1:0] wr_idx_o,
  output logic [7:0] wr_data_o,
  output logic sel_o,
  output logic [ADDR_W-1:0] ptr_o
);

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] vlo_sy;
    logic scl_d;
    logic sda_d;
    rss_pkg::rss_dev_st_e st;
    rss_pkg::rss_kind_e kind;
    logic rw;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic mack;
    logic [ADDR_W-1:0] ptr;
    logic [NUM_REGS-1:0][7:0] mem;
    logic sda_lvl;
    logic sda_oe;
    logic wr_stb;
    logic [ADDR_W-1:0] wr_idx;
    logic [7:0] wr_data;
    logic sel;
  } rss_dev_s;

  rss_dev_s r;
  rss_dev_s n;

  // Wraps at the top of the image so long bursts keep cycling.
  function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] p);
    next_ptr = (p == ADDR_W'(NUM_REGS - 1)) ? '0 : ADDR_W'(p + 1'b1);
  endfunction

  logic scl_h;
  logic sda_h;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    n.wr_stb = 1'b0;
    n.scl_sy = {r.scl_sy[0], bus.scl};
    n.sda_sy = {r.sda_sy[0], bus.sda};
    n.vlo_sy = {r.vlo_sy[0], vcc_low_i};
    scl_h = r.scl_sy[1];
    sda_h = r.sda_sy[1];
    n.scl_d = scl_h;
    n.sda_d = sda_h;
    rise = scl_h && !r.scl_d;
    fall = !scl_h && r.scl_d;
    start = scl_h && r.scl_d && r.sda_d && !sda_h;
    stop = scl_h && r.scl_d && !r.sda_d && sda_h;
    if (cal_we_i)
    begin
      n.mem[cal_idx_i] = cal_data_i;
    end
    if (r.vlo_sy[1])
    begin
      // Nothing on the wires is trusted while the supply is out of tolerance.
      n.st = rss_pkg::DEV_IDLE;
      n.ptr = '0;
      n.sda_oe = 1'b0;
      n.sel = 1'b0;
    end
    else if (start)
    begin
      n.st = rss_pkg::DEV_RECV;
      n.kind = rss_pkg::KIND_ADDR;
      n.cnt = '0;
      n.sda_oe = 1'b0;
      n.sel = 1'b0;
    end
    else if (stop)
    begin
      n.st = rss_pkg::DEV_IDLE;
      n.sda_oe = 1'b0;
      n.sel = 1'b0;
    end
    else
    begin
      unique case (r.st)
        rss_pkg::DEV_IDLE:
        begin
          n.sda_oe = 1'b0;
        end
        rss_pkg::DEV_RECV:
        begin
          if (rise)
          begin
            n.sh = {r.sh[6:0], sda_h};
            n.cnt = 3'(r.cnt + 1'b1);
            if (r.cnt == rss_pkg::LAST_BIT)
            begin
              n.st = rss_pkg::DEV_RDONE;
            end
          end
        end
        rss_pkg::DEV_RDONE:
        begin
          if (fall)
          begin
            n.st = rss_pkg::DEV_ACK;
            n.sda_oe = 1'b1;
            unique case (r.kind)
              rss_pkg::KIND_ADDR:
              begin
                if (r.sh[7:1] == rss_pkg::SLAVE_ADDR)
                begin
                  n.rw = r.sh[0];
                  n.sel = 1'b1;
                end
                else
                begin
                  n.st = rss_pkg::DEV_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
              rss_pkg::KIND_WORD:
              begin
                n.ptr = r.sh[ADDR_W-1:0];
              end
              default:
              begin
                n.mem[r.ptr] = r.sh;
                n.wr_stb = 1'b1;
                n.wr_idx = r.ptr;
                n.wr_data = r.sh;
                n.ptr = next_ptr(r.ptr);
              end
            endcase
          end
        end
        rss_pkg::DEV_ACK:
        begin
          // The low is held until SCL falls, covering the whole high phase.
          if (fall)
          begin
            n.cnt = '0;
            n.sda_oe = 1'b0;
            if (r.rw && r.kind == rss_pkg::KIND_ADDR)
            begin
              n.sh = r.mem[r.ptr];
              n.sda_oe = !r.mem[r.ptr][7];
              n.st = rss_pkg::DEV_SEND;
            end
            else
            begin
              n.st = rss_pkg::DEV_RECV;
              n.kind = (r.kind == rss_pkg::KIND_ADDR) ? rss_pkg::KIND_WORD : rss_pkg::KIND_DATA;
            end
          end
        end
        rss_pkg::DEV_SEND:
        begin
          if (fall)
          begin
            if (r.cnt == rss_pkg::LAST_BIT)
            begin
              n.sda_oe = 1'b0;
              n.st = rss_pkg::DEV_MACK;
            end
            else
            begin
              n.sh = {r.sh[6:0], 1'b0};
              n.cnt = 3'(r.cnt + 1'b1);
              n.sda_oe = !r.sh[6];
            end
          end
        end
        rss_pkg::DEV_MACK:
        begin
          if (rise)
          begin
            n.mack = !sda_h;
          end
          if (fall)
          begin
            n.cnt = '0;
            if (r.mack)
            begin
              n.ptr = next_ptr(r.ptr);
              n.sh = r.mem[next_ptr(r.ptr)];
              n.sda_oe = !r.mem[next_ptr(r.ptr)][7];
              n.st = rss_pkg::DEV_SEND;
            end
            else
            begin
              n.sda_oe = 1'b0;
              n.st = rss_pkg::DEV_IDLE;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.sda_d_out = r.sda_lvl;
  assign bus.sda_d_oe = r.sda_oe;
  assign regs_o = r.mem;
  assign wr_stb_o = r.wr_stb;
  assign wr_idx_o = r.wr_idx;
  assign wr_data_o = r.wr_data;
  assign sel_o = r.sel;
  assign ptr_o = r.ptr;

endmodule // rss_dev

// >>> src/rss_pkg.sv
// Purpose: Shared constants and enumerations for the clock-calendar serial port.
// Assumes: 100 MHz system clock on both ends.
// Notes: Byte order of the clock-calendar image is fixed by the indices below.
package rss_pkg;

  // 7-bit form of the slave address byte d0 (direction bit excluded).
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam int NUM_REGS = 8;
  localparam logic [7:0] REG_RST = 8'h00;

  // Sequential byte order of the clock-calendar image.
  localparam logic [2:0] IDX_SECONDS = 3'h0;
  localparam logic [2:0] IDX_MINUTES = 3'h1;
  localparam logic [2:0] IDX_CENT_HOURS = 3'h2;
  localparam logic [2:0] IDX_DAY = 3'h3;
  localparam logic [2:0] IDX_DATE = 3'h4;
  localparam logic [2:0] IDX_MONTH = 3'h5;
  localparam logic [2:0] IDX_YEARS = 3'h6;
  localparam logic [2:0] IDX_CONTROL = 3'h7;

  // Byte framing: eight data bits, then one acknowledge slot.
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] LAST_SLOT = 4'h8;

  // Master clock timing: one SCL period is four quarters.
  localparam int CLK_NS = 10;
  localparam int T_QTR_NS = 2500;
  localparam int QTR_CYC = (T_QTR_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {DEV_IDLE, DEV_RECV, DEV_RDONE, DEV_ACK, DEV_SEND, DEV_MACK} rss_dev_st_e;
  typedef enum logic [1:0] {KIND_ADDR, KIND_WORD, KIND_DATA} rss_kind_e;
  typedef enum logic [1:0] {HST_IDLE, HST_START, HST_BIT, HST_STOP} rss_hst_st_e;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} rss_op_e;

endpackage

// >>> src/rss_if.sv
// Purpose: Two-wire link between the bus master and the clock-calendar slave.
// Assumes: Both lines are open drain with a pull-up; an enable high with a low level pulls the line low.
// Notes: Only this interface resolves the wire levels.
`timescale 1ns/1ns
interface rss_if;
  logic scl_h_out;
  logic scl_h_oe;
  logic sda_h_out;
  logic sda_h_oe;
  logic sda_d_out;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Pull-up wins unless some driver enables a low.
  assign scl = !(scl_h_oe && !scl_h_out);
  assign sda = !(sda_h_oe && !sda_h_out) && !(sda_d_oe && !sda_d_out);

  modport dev (input scl, input sda, output sda_d_out, output sda_d_oe);
  modport host (input scl, input sda, output scl_h_out, output scl_h_oe, output sda_h_out, output sda_h_oe);
endinterface

// >>> src/rss_host.sv
// Purpose: Bus master end that runs START, STOP and byte slots on command.
// Assumes: Sole master on the link; no clock stretching by the slave.
// Notes: SCL is divided from clk_i in quarter periods; SDA is synchronised before sampling.
`timescale 1ns/1ns
module rss_host #(
  parameter int QTR_CYC = rss_pkg::QTR_CYC,
  parameter int DIV_W = $clog2(QTR_CYC + 1)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial link.
  rss_if.host bus,
  // Command port.
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_ack_i,
  output logic cmd_ready_o,
  // Response port.
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o
);

  typedef struct packed {
    rss_pkg::rss_hst_st_e st;
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [DIV_W-1:0] div;
    logic [1:0] sda_sy;
    logic lvl;
    logic scl_oe;
    logic sda_oe;
    logic rdy;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } rss_hst_s;

  rss_hst_s r;
  rss_hst_s n;
  logic tick;
  logic last_ph;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    n.rsp_valid = 1'b0;
    n.sda_sy = {r.sda_sy[0], bus.sda};
    tick = (r.div == DIV_W'(QTR_CYC - 1));
    n.div = tick ? '0 : DIV_W'(r.div + 1'b1);
    last_ph = (r.ph == 2'h3);
    if (r.st == rss_pkg::HST_IDLE)
    begin
      n.rdy = 1'b1;
      if (cmd_valid_i && r.rdy)
      begin
        n.rdy = 1'b0;
        n.ph = '0;
        n.cnt = '0;
        n.div = '0;
        unique case (rss_pkg::rss_op_e'(cmd_op_i))
          rss_pkg::OP_START: n.st = rss_pkg::HST_START;
          rss_pkg::OP_STOP: n.st = rss_pkg::HST_STOP;
          rss_pkg::OP_WRITE:
          begin
            n.st = rss_pkg::HST_BIT;
            n.tx = {cmd_data_i, 1'b1};
          end
          rss_pkg::OP_READ:
          begin
            n.st = rss_pkg::HST_BIT;
            n.tx = {8'hff, !cmd_ack_i};
          end
        endcase
      end
    end
    else if (tick)
    begin
      n.ph = 2'(r.ph + 1'b1);
      unique case (r.st)
        rss_pkg::HST_START:
        begin
          // Released SDA first so a repeated START never looks like STOP.
          unique case (r.ph)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            2'h3: n.scl_oe = 1'b1;
          endcase
        end
        rss_pkg::HST_STOP:
        begin
          unique case (r.ph)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            2'h3: n.sda_oe = 1'b0;
          endcase
        end
        default:
        begin
          unique case (r.ph)
            2'h0: n.sda_oe = !r.tx[8];
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.rx = {r.rx[7:0], r.sda_sy[1]};
            2'h3:
            begin
              n.scl_oe = 1'b1;
              n.tx = {r.tx[7:0], 1'b1};
              n.cnt = 4'(r.cnt + 1'b1);
            end
          endcase
        end
      endcase
      if (last_ph && (r.st != rss_pkg::HST_BIT || r.cnt == rss_pkg::LAST_SLOT))
      begin
        n.st = rss_pkg::HST_IDLE;
        n.rsp_valid = (r.st == rss_pkg::HST_BIT);
        n.rsp_data = r.rx[8:1];
        n.rsp_nack = r.rx[0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.scl_h_out = r.lvl;
  assign bus.scl_h_oe = r.scl_oe;
  assign bus.sda_h_out = r.lvl;
  assign bus.sda_h_oe = r.sda_oe;
  assign cmd_ready_o = r.rdy;
  assign rsp_valid_o = r.rsp_valid;
  assign rsp_data_o = r.rsp_data;
  assign rsp_nack_o = r.rsp_nack;

endmodule // rss_host

// >>> testbench/rss_properties.sv
// Purpose: Wire checks of the serial link between host and device.
// Assumes: Link signals of rss_if and the supply flag, sampled by clk_i.
// Notes: Framing is decoded here from the resolved wire levels.
`timescale 1ns/1ns
module rss_properties (
  // Clock, reset and supply.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic vcc_low_i,
  // Link signals.
  input wire logic scl_h_out,
  input wire logic scl_h_oe,
  input wire logic sda_h_out,
  input wire logic sda_h_oe,
  input wire logic sda_d_out,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, frame_r, first_r, rd_r, sel_r, nack_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  wire logic rise_w = scl && !scl_q;
  wire logic start_w = scl && scl_q && sda_q && !sda;
  wire logic stop_w = scl && scl_q && !sda_q && sda;
  wire logic slot9_w = rise_w && (cnt_r == 4'h8);

  //////////////////////////////////////////////////////////////////////////////
  // Frame decoder; selection drops at once on low supply, ahead of the device.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {scl_q, sda_q} <= 2'h3;
      {frame_r, first_r, rd_r, sel_r, nack_r} <= 5'h00;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_w)
      begin
        {frame_r, first_r, sel_r, nack_r} <= 4'hc;
        cnt_r <= 4'h0;
      end
      else if (stop_w)
        {frame_r, sel_r} <= 2'h0;
      else if (rise_w)
      begin
        sh_r <= {sh_r[6:0], sda};
        cnt_r <= slot9_w ? 4'h0 : cnt_r + 4'h1;
        if (slot9_w)
          first_r <= 1'b0;
        if (slot9_w && first_r)
          {sel_r, rd_r} <= {sh_r[7:1] == rss_pkg::SLAVE_ADDR, sh_r[0]};
        if (slot9_w && !first_r && sel_r && rd_r && sda)
          nack_r <= 1'b1;
      end
      if (vcc_low_i)
        sel_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_addr_ack: assert property (slot9_w && first_r |-> sda_d_oe == (sh_r[7:1] == rss_pkg::SLAVE_ADDR && !vcc_low_i))
    else $error("address acknowledge wrong");
  a_write_ack: assert property (slot9_w && !first_r && sel_r && !rd_r |-> sda_d_oe)
    else $error("written byte not acknowledged");
  a_quiet_outside: assert property (sda_d_oe |-> frame_r)
    else $error("device drives outside a frame");
  a_hold_high: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_nack_release: assert property (nack_r |-> !sda_d_oe)
    else $error("device drives after missing acknowledge");
  a_supply_release: assert property (vcc_low_i [*4] |-> !sda_d_oe)
    else $error("device drives during low supply");
  a_drive_bounded: assert property ($rose(sda_d_oe) |-> ##[1:400] !sda_d_oe)
    else $error("device holds data line too long");
  a_open_drain: assert property (sda_d_oe |-> !sda_d_out)
    else $error("device drives data line high");
  a_host_stable: assert property ($changed(sda_h_oe) && scl |-> start_w || stop_w)
    else $error("host data changed while clock high");
  a_host_drain: assert property (!(scl_h_oe && scl_h_out) && !(sda_h_oe && sda_h_out))
    else $error("host drives a line high");
  c_write_ack: cover property (slot9_w && !first_r && sel_r && !rd_r);
  c_read_nack: cover property (nack_r);
  c_restart: cover property (start_w && frame_r);
endmodule // rss_properties

// >>> testbench/tb.sv
// Purpose: Host and device joined on one link, driven through their user ports.
// Assumes: Quarter period shortened to 8 cycles.
// Notes: Expected image is kept in exp_r.
`timescale 1ns/1ns
module tb;
  logic clk_i, rst_b_i, vcc_low_i, cal_we_i, cmd_valid_i, cmd_ack_i;
  logic [2:0] cal_idx_i, wr_idx_o, ptr_o;
  logic [7:0] cal_data_i, cmd_data_i, wr_data_o, rsp_data_o;
  logic [1:0] cmd_op_i;
  logic [rss_pkg::NUM_REGS-1:0][7:0] regs_o;
  logic wr_stb_o, sel_o, cmd_ready_o, rsp_valid_o, rsp_nack_o;
  logic [7:0] exp_r [8];
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int stb_count = 0;
  int rsp_count = 0;

  rss_if link ();
  rss_dev u_rss_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(link), .vcc_low_i(vcc_low_i),
    .cal_we_i(cal_we_i), .cal_idx_i(cal_idx_i), .cal_data_i(cal_data_i), .regs_o(regs_o),
    .wr_stb_o(wr_stb_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o), .sel_o(sel_o), .ptr_o(ptr_o));
  rss_host #(.QTR_CYC(8)) u_rss_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(link),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i), .cmd_ack_i(cmd_ack_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_nack_o(rsp_nack_o));
  rss_properties u_rss_properties (.clk_i(clk_i), .rst_b_i(rst_b_i), .vcc_low_i(vcc_low_i),
    .scl_h_out(link.scl_h_out), .scl_h_oe(link.scl_h_oe), .sda_h_out(link.sda_h_out),
    .sda_h_oe(link.sda_h_oe), .sda_d_out(link.sda_d_out), .sda_d_oe(link.sda_d_oe),
    .scl(link.scl), .sda(link.sda));

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ready is looked at between edges, so the next rising edge takes the command.
  task automatic send(input rss_pkg::rss_op_e op, input logic [7:0] d, input logic ack);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_data_i = d;
    cmd_ack_i = ack;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    @(negedge clk_i);
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic put(input logic [7:0] d, input logic nack);
    send(rss_pkg::OP_WRITE, d, 1'b0);
    check("write nack", {7'h00, rsp_nack_o}, {7'h00, nack});
  endtask

  task automatic get(input logic [7:0] exp, input logic ack);
    send(rss_pkg::OP_READ, 8'h00, ack);
    check("read data", rsp_data_o, exp);
    check("read ack slot", {7'h00, rsp_nack_o}, {7'h00, !ack});
  endtask

  task automatic check_image();
    for (int i = 0; i < 8; i++)
      check("image byte", regs_o[i], exp_r[i]);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // Pulses are counted mid-cycle so the edge that launches them is never raced.
  always @(negedge clk_i)
  begin
    if (wr_stb_o === 1'b1)
      stb_count++;
    if (rsp_valid_o === 1'b1)
      rsp_count++;
  end

  initial
  begin
    {rst_b_i, vcc_low_i, cal_we_i, cmd_valid_i, cmd_ack_i} = 5'h00;
    {cal_idx_i, cal_data_i, cmd_data_i, cmd_op_i} = 21'h000000;
    for (int i = 0; i < 8; i++)
      exp_r[i] = 8'h00;
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check_image();
    check("reset pointer", {5'h00, ptr_o}, 8'h00);
    // Write three bytes from index 6 so the pointer wraps.
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd0, 1'b0);
    put(8'h06, 1'b0);
    for (int i = 0; i < 3; i++)
      put(8'h11 * (i + 1), 1'b0);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    {exp_r[6], exp_r[7], exp_r[0]} = 24'h112233;
    check("pointer", {5'h00, ptr_o}, 8'h01);
    check("write index", {5'h00, wr_idx_o}, 8'h00);
    // Fill the remaining bytes from the calendar side.
    for (int i = 1; i < 6; i++)
    begin
      cal_we_i = 1'b1;
      cal_idx_i = 3'(i);
      cal_data_i = 8'h40 + 8'(i);
      exp_r[i] = cal_data_i;
      @(negedge clk_i);
    end
    cal_we_i = 1'b0;
    @(negedge clk_i);
    check_image();
    // Read across the wrap after a repeated start; the last byte is refused.
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd0, 1'b0);
    put(8'h05, 1'b0);
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd1, 1'b0);
    for (int i = 0; i < 4; i++)
      get(exp_r[(5 + i) % 8], i < 3);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    check("pointer", {5'h00, ptr_o}, 8'h00);
    // Current-pointer read shows the refused byte did not advance it.
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd1, 1'b0);
    check("selected", {7'h00, sel_o}, 8'h01);
    get(exp_r[0], 1'b0);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    // Foreign address is left unanswered.
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'ha0, 1'b1);
    check("selected", {7'h00, sel_o}, 8'h00);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    // Supply drops in the middle of a data byte.
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd0, 1'b0);
    put(8'h02, 1'b0);
    fork
      send(rss_pkg::OP_WRITE, 8'h5a, 1'b0);
      begin
        repeat (40) @(negedge clk_i);
        vcc_low_i = 1'b1;
      end
    join
    check("aborted nack", {7'h00, rsp_nack_o}, 8'h01);
    check("pointer", {5'h00, ptr_o}, 8'h00);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    // Own address while the supply is low must go unanswered.
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd0, 1'b1);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    check_image();
    vcc_low_i = 1'b0;
    repeat (6) @(negedge clk_i);
    send(rss_pkg::OP_START, 8'h00, 1'b0);
    put(8'hd0, 1'b0);
    put(8'h02, 1'b0);
    put(8'h5a, 1'b0);
    send(rss_pkg::OP_STOP, 8'h00, 1'b0);
    exp_r[2] = 8'h5a;
    check_image();
    check("write data", wr_data_o, 8'h5a);
    check("write strobes", 8'(stb_count), 8'h04);
    check("byte responses", 8'(rsp_count), 8'h16);
    print_verdict();
  end
endmodule // tb
